// *** core/fms_defines.vh ***
// Purpose: constants for the float move/store unit
// Assumes: included by fms_unit.v only
// Notes: byte offsets on the apb bus, field positions, exception codes
`ifndef FMS_DEFINES_VH
`define FMS_DEFINES_VH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define FMS_CTRL_OFF 12'h000
`define FMS_STAT_OFF 12'h004
`define FMS_MASK_OFF 12'h008
`define FMS_EXC_OFF 12'h00c
`define FMS_FIDX_OFF 12'h010
`define FMS_FDATA_OFF 12'h014

// ----------------------------------------
// status / mask bit positions
// ----------------------------------------
`define FMS_ST_DONE 0
`define FMS_ST_FLOAT_DISABLED_EXC 1
`define FMS_ST_MEMFLT 2
`define FMS_ST_ILLEGAL 3
`define FMS_ST_W 4

// ----------------------------------------
// opcode fields
// ----------------------------------------
`define FMS_OP_MAJOR 4'hf
`define FMS_LO_MOVE 4'hc
`define FMS_LO_STIND 4'ha
`define FMS_LO_STDEC 4'hb
`define FMS_LO_STIDX 4'h7

// ----------------------------------------
// exception codes
// ----------------------------------------
`define FMS_EXC_NONE 3'h0
`define FMS_EXC_SLOTDIS 3'h1
`define FMS_EXC_FLOAT_DISABLED_EXC 3'h2
`define FMS_EXC_WADDR 3'h3
`define FMS_EXC_WTLB 3'h4
`define FMS_EXC_WPROT 3'h5
`define FMS_EXC_FIRSTWR 3'h6
`define FMS_EXC_ILLEGAL 3'h7

// ----------------------------------------
// address steps
// ----------------------------------------
`define FMS_DEC_SINGLE 32'h00000004
`define FMS_DEC_PAIR 32'h00000008
`define FMS_WORD_STEP 32'h00000004

`endif

// *** core/fms_unit.v ***
// Purpose: decode and execute float register moves and float stores
// Assumes: one clock pclk at 100 MHz, presetn async active low
// Notes: register banks live here; general registers arrive with the instruction
//
// What this block does
// RULE1 - pair forms need precision 0, size 1
// RULE2 - single forms need transfer size 0
// RULE3 - disabled fpu: slot or plain exception first
// RULE4 - stores add four memory exceptions; moves none
// RULE5 - effective addresses wrap modulo two to 32
// RULE6 - moves never interpret data or touch flags
// RULE7 - single copy is a raw 32-bit copy
// RULE8 - single store writes to address in Rn
// RULE9 - single predecrement store uses Rn minus 4
// RULE10 - indexed stores address index reg plus Rn
// RULE11 - pair stores write two consecutive words
// RULE12 - extended pair store to address in Rn
// RULE13 - extended predecrement store uses Rn minus 8
// RULE14 - extended pair copied into primary pair
// RULE15 - extended pair copied to extended pair whole
// RULE16 - pair fault suppresses base register update
// RULE17 - 3-bit pair fields; mode mismatch is illegal
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`include "fms_defines.vh"

module fms_unit #(
	parameter NREG = 32
)(
	pclk,
	presetn,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	instr_valid,
	instr_word,
	instr_in_delay_slot,
	float_unit_disabled,
	precision_mode_bit,
	transfer_size_bit,
	instr_rn_val,
	index_general_reg_val,
	instr_busy,
	instr_done,
	exc_valid,
	exc_code,
	gr_wb_en,
	gr_wb_idx,
	gr_wb_data,
	mem_wr_req,
	mem_wr_addr,
	mem_wr_data,
	mem_ack,
	mem_fault,
	mem_fault_kind,
	irq
);
	input wire pclk;
	input wire presetn;
	input wire psel;
	input wire penable;
	input wire pwrite;
	input wire [11:0] paddr;
	input wire [31:0] pwdata;
	output reg [31:0] prdata;
	output reg pready;
	output reg pslverr;
	input wire instr_valid;
	input wire [15:0] instr_word;
	input wire instr_in_delay_slot;
	input wire float_unit_disabled;
	input wire precision_mode_bit;
	input wire transfer_size_bit;
	input wire [31:0] instr_rn_val;
	input wire [31:0] index_general_reg_val;
	output reg instr_busy;
	output reg instr_done;
	output reg exc_valid;
	output reg [2:0] exc_code;
	output reg gr_wb_en;
	output reg [3:0] gr_wb_idx;
	output reg [31:0] gr_wb_data;
	output reg mem_wr_req;
	output reg [31:0] mem_wr_addr;
	output reg [31:0] mem_wr_data;
	input wire mem_ack;
	input wire mem_fault;
	input wire [1:0] mem_fault_kind;
	output reg irq;

	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam ST_IDLE = 2'd0;
	localparam ST_WORD0 = 2'd1;
	localparam ST_WORD1 = 2'd2;

	// float banks: index 0..15 primary, 16..31 extended
	reg [31:0] freg [0:NREG-1];
	reg [1:0] state_reg;
	reg ctrl_en_reg;
	reg [`FMS_ST_W-1:0] stat_reg;
	reg [`FMS_ST_W-1:0] mask_reg;
	reg [4:0] fidx_reg;
	reg pair_reg;
	reg wb_pend_reg;
	reg [3:0] rn_idx_reg;
	reg [31:0] ea_reg;
	reg [31:0] word1_reg;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	// decoded view of the offered word; only meaningful while take is high
	reg is_move;
	reg is_store;
	reg legal;
	reg [4:0] src_idx;
	reg [4:0] dst_idx;
	reg [31:0] ea;
	reg base_wb;
	wire [3:0] lo = instr_word[3:0];
	wire sz = transfer_size_bit;
	// one instruction at a time: a store in flight holds off the next offer
	wire take = instr_valid && ctrl_en_reg && (state_reg == ST_IDLE) && !instr_busy;
	// a transfer counts only at the edge where pready is seen high
	wire apb_wr = psel && penable && pready && pwrite;
	wire apb_rd = psel && penable && pready && !pwrite;

	// pair fields are 3 bits selecting even pairs, bank bit beside them
	always @*
	begin
		is_move = (instr_word[15:12] == `FMS_OP_MAJOR) && (lo == `FMS_LO_MOVE);
		is_store = (instr_word[15:12] == `FMS_OP_MAJOR) && ((lo == `FMS_LO_STIND) ||
			(lo == `FMS_LO_STDEC) || (lo == `FMS_LO_STIDX));
		legal = (is_move || is_store) && (!sz || !precision_mode_bit); // RULE1 RULE2 RULE17
		// single forms use 4-bit fields, pair forms a bank bit over a 3-bit pair
		src_idx = sz ? {instr_word[4], instr_word[7:5], 1'b0} : {1'b0, instr_word[7:4]}; // RULE17
		dst_idx = sz ? {instr_word[8], instr_word[11:9], 1'b0} : {1'b0, instr_word[11:8]}; // RULE17
		base_wb = (lo == `FMS_LO_STDEC);
		// 32-bit sums drop their carry on purpose, so addresses wrap
		case (lo)
			`FMS_LO_STDEC: ea = instr_rn_val - (sz ? `FMS_DEC_PAIR : `FMS_DEC_SINGLE); // RULE9 RULE13 RULE5
			`FMS_LO_STIDX: ea = index_general_reg_val + instr_rn_val; // RULE10 RULE5
			default: ea = instr_rn_val; // RULE8 RULE12
		endcase
	end

	// ----------------------------------------
	// float register banks
	// ----------------------------------------
	// raw bit copies only; no float flags exist on this path
	always @(posedge pclk)
	begin
		// a move wins over an fdata write in the same cycle
		if (take && legal && is_move && !float_unit_disabled)
		begin
			freg[dst_idx] <= freg[src_idx]; // RULE7 RULE14 RULE15 RULE6
			if (sz)
				freg[dst_idx | 5'h01] <= freg[src_idx | 5'h01]; // RULE14 RULE15
		end
		else if (apb_wr && (paddr == `FMS_FDATA_OFF))
			freg[fidx_reg] <= pwdata;
	end

	// ----------------------------------------
	// execute sequencer
	// ----------------------------------------
	// base update is held back until every word landed cleanly
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= ST_IDLE;
			instr_busy <= 1'b0;
			instr_done <= 1'b0;
			exc_valid <= 1'b0;
			exc_code <= `FMS_EXC_NONE;
			gr_wb_en <= 1'b0;
			gr_wb_idx <= 4'h0;
			gr_wb_data <= 32'h00000000;
			mem_wr_req <= 1'b0;
			mem_wr_addr <= 32'h00000000;
			mem_wr_data <= 32'h00000000;
			pair_reg <= 1'b0;
			wb_pend_reg <= 1'b0;
			rn_idx_reg <= 4'h0;
			ea_reg <= 32'h00000000;
			word1_reg <= 32'h00000000;
		end
		else
		begin
			instr_done <= 1'b0;
			exc_valid <= 1'b0;
			gr_wb_en <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					if (take)
					begin
						// checking order: illegal first, then fpu disabled, then the memory side
						if (!legal)
						begin
							exc_valid <= 1'b1;
							exc_code <= `FMS_EXC_ILLEGAL; // RULE17
						end
						else if (float_unit_disabled)
						begin
							exc_valid <= 1'b1;
							exc_code <= instr_in_delay_slot ? `FMS_EXC_SLOTDIS : `FMS_EXC_FLOAT_DISABLED_EXC; // RULE3
						end
						else if (is_move)
						begin
							// moves finish at once and never reach the memory path
							instr_done <= 1'b1; // RULE4
							exc_code <= `FMS_EXC_NONE;
						end
						else
						begin
							// latch all that later words need; the core may change its inputs meanwhile
							state_reg <= ST_WORD0;
							instr_busy <= 1'b1;
							mem_wr_req <= 1'b1;
							mem_wr_addr <= ea;
							mem_wr_data <= freg[src_idx]; // RULE8 RULE11
							word1_reg <= freg[src_idx | 5'h01];
							ea_reg <= ea;
							pair_reg <= sz;
							wb_pend_reg <= base_wb;
							rn_idx_reg <= instr_word[11:8];
						end
					end
				end
				ST_WORD0, ST_WORD1:
				begin
					if (mem_ack)
					begin
						if (mem_fault)
						begin
							// no base update on fault, nothing further written
							state_reg <= ST_IDLE;
							instr_busy <= 1'b0;
							mem_wr_req <= 1'b0;
							exc_valid <= 1'b1;
							exc_code <= `FMS_EXC_WADDR + {1'b0, mem_fault_kind}; // RULE4 RULE16
						end
						else if (pair_reg && (state_reg == ST_WORD0))
						begin
							state_reg <= ST_WORD1;
							// second word of a pair lands one word higher
							mem_wr_addr <= ea_reg + `FMS_WORD_STEP; // RULE11 RULE5
							mem_wr_data <= word1_reg; // RULE11
						end
						else
						begin
							state_reg <= ST_IDLE;
							instr_busy <= 1'b0;
							mem_wr_req <= 1'b0;
							instr_done <= 1'b1;
							exc_code <= `FMS_EXC_NONE;
							// base write-back waits until the last word landed cleanly
							gr_wb_en <= wb_pend_reg; // RULE9 RULE13 RULE16
							gr_wb_idx <= rn_idx_reg;
							gr_wb_data <= ea_reg; // RULE9 RULE13
						end
					end
				end
				// unused state code: drop back to idle rather than hang
				default:
				begin
					state_reg <= ST_IDLE;
					instr_busy <= 1'b0;
					mem_wr_req <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// apb slave and interrupt registers
	// ----------------------------------------
	// one wait state keeps pready and prdata straight from flops
	wire [`FMS_ST_W-1:0] ev_set = {exc_valid && (exc_code == `FMS_EXC_ILLEGAL),
		exc_valid && (exc_code >= `FMS_EXC_WADDR) && (exc_code <= `FMS_EXC_FIRSTWR),
		exc_valid && ((exc_code == `FMS_EXC_SLOTDIS) || (exc_code == `FMS_EXC_FLOAT_DISABLED_EXC)),
		instr_done};
	// unmapped offsets answer with pslverr and read as zero
	wire mapped = (paddr == `FMS_CTRL_OFF) || (paddr == `FMS_STAT_OFF) || (paddr == `FMS_MASK_OFF) ||
		(paddr == `FMS_EXC_OFF) || (paddr == `FMS_FIDX_OFF) || (paddr == `FMS_FDATA_OFF);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			ctrl_en_reg <= 1'b0;
			stat_reg <= {`FMS_ST_W{1'b0}};
			mask_reg <= {`FMS_ST_W{1'b0}};
			fidx_reg <= 5'h00;
			irq <= 1'b0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			if (apb_wr && (paddr == `FMS_CTRL_OFF))
				ctrl_en_reg <= pwdata[0];
			if (apb_wr && (paddr == `FMS_MASK_OFF))
				mask_reg <= pwdata[`FMS_ST_W-1:0];
			if (apb_wr && (paddr == `FMS_FIDX_OFF))
				fidx_reg <= pwdata[4:0];
			// write one to clear; a new event in the same cycle wins
			if (apb_wr && (paddr == `FMS_STAT_OFF))
				stat_reg <= (stat_reg & ~pwdata[`FMS_ST_W-1:0]) | ev_set;
			else
				stat_reg <= stat_reg | ev_set;
			irq <= |(((stat_reg | ev_set) & ~((apb_wr && (paddr == `FMS_STAT_OFF)) ?
				pwdata[`FMS_ST_W-1:0] : {`FMS_ST_W{1'b0}}) | ev_set) & mask_reg);
			// read data loads in the setup cycle so it stands through the access phase
			if (psel && !penable && !pwrite)
			begin
				case (paddr)
					`FMS_CTRL_OFF: prdata <= {31'h00000000, ctrl_en_reg};
					`FMS_STAT_OFF: prdata <= {28'h0000000, stat_reg};
					`FMS_MASK_OFF: prdata <= {28'h0000000, mask_reg};
					`FMS_EXC_OFF: prdata <= {27'h0000000, instr_busy, 1'b0, exc_code};
					`FMS_FIDX_OFF: prdata <= {27'h0000000, fidx_reg};
					`FMS_FDATA_OFF: prdata <= freg[fidx_reg];
					default: prdata <= 32'h00000000;
				endcase
			end
			else if (apb_rd)
				prdata <= prdata;
		end
	end

endmodule // fms_unit

// *** test/fms_mem_model.sv ***
// Purpose: memory write path that answers store words
// Assumes: request, address and data held until acked
// Notes: 0..3 wait cycles a word; faults only on command
`timescale 1ns/1ps
module fms_mem_model (
	input logic pclk,
	input logic presetn,
	input logic mem_wr_req,
	input logic [31:0] mem_wr_addr,
	input logic [31:0] mem_wr_data,
	input logic fault_next,
	input logic [1:0] fault_kind,
	input logic fault_late,
	output logic mem_ack,
	output logic mem_fault,
	output logic [1:0] mem_fault_kind
);
	logic [31:0] wa [0:15];
	logic [31:0] wd [0:15];
	int n_wr, wait_cnt, wcnt;
	logic hit;
	// the fault lands on the first word, or on the second while fault_late is high
	assign hit = fault_next && (wcnt == (fault_late ? 1 : 0));
	// one ack a word; kind toggles after an ack and while idle, and holds through wait cycles, so a stale code never looks valid
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_ack <= 1'b0;
			mem_fault <= 1'b0;
			mem_fault_kind <= 2'h0;
			n_wr <= 0;
			wait_cnt <= 0;
			wcnt <= 0;
		end
		else if (mem_ack || !mem_wr_req)
		begin
			mem_ack <= 1'b0;
			mem_fault <= 1'b0;
			mem_fault_kind <= ~mem_fault_kind;
			wait_cnt <= $urandom_range(3);
			if (!mem_wr_req)
				wcnt <= 0;
		end
		else if (wait_cnt != 0)
			wait_cnt <= wait_cnt - 1;
		else
		begin
			mem_ack <= 1'b1;
			mem_fault <= hit;
			mem_fault_kind <= fault_kind;
			wa[n_wr % 16] <= mem_wr_addr;
			wd[n_wr % 16] <= mem_wr_data;
			n_wr <= n_wr + (hit ? 0 : 1);
			wcnt <= wcnt + 1;
		end
	end
endmodule // fms_mem_model

// *** test/fms_unit_asserts.sv ***
// Purpose: port checks of the float move/store unit
// Assumes: one clock pclk, presetn async active low
// Notes: enable bit is internal, so checks key on outcomes
`timescale 1ns/1ps
module fms_unit_asserts (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pready,
	input logic instr_valid,
	input logic instr_busy,
	input logic instr_in_delay_slot,
	input logic float_unit_disabled,
	input logic precision_mode_bit,
	input logic transfer_size_bit,
	input logic exc_valid,
	input logic [2:0] exc_code,
	input logic gr_wb_en,
	input logic mem_wr_req,
	input logic [31:0] mem_wr_addr,
	input logic mem_ack,
	input logic mem_fault,
	input logic [1:0] mem_fault_kind
);
	// one domain, so clock and reset are given once
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_apb_one_wait: assert property ((psel && !penable) ##1 (psel && penable) |=> pready) else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_slot_first: assert property (exc_valid && $past(instr_valid && !instr_busy && float_unit_disabled
		&& instr_in_delay_slot) |-> exc_code inside {3'h1, 3'h7}) else $error("slot code");
	a_plain_dis: assert property (exc_valid && $past(instr_valid && !instr_busy && float_unit_disabled
		&& !instr_in_delay_slot) |-> exc_code inside {3'h2, 3'h7}) else $error("disabled code");
	a_illegal_mode: assert property (exc_valid && $past(instr_valid && !instr_busy && precision_mode_bit
		&& transfer_size_bit) |-> exc_code == 3'h7) else $error("mode code");
	a_fault_stops: assert property (mem_wr_req && mem_ack && mem_fault |=> exc_valid && !mem_wr_req && !gr_wb_en
		&& exc_code == 3'h3 + $past(mem_fault_kind)) else $error("fault");
	a_pair_step: assert property ((mem_wr_req && mem_ack && !mem_fault) ##1 mem_wr_req
		|-> mem_wr_addr == $past(mem_wr_addr) + 32'h4) else $error("word step");
	a_store_gated: assert property ($rose(mem_wr_req) |-> !$past(float_unit_disabled
		|| (precision_mode_bit && transfer_size_bit))) else $error("gated store");
endmodule // fms_unit_asserts
bind fms_unit fms_unit_asserts fms_unit_asserts_inst (.*);

// *** test/fms_unit_tb.sv ***
// Purpose: self-checking bench of the float move/store unit
// Assumes: memory model on the write path
// Notes: seed 33; expectations from exp_ea and the float shadow fv
`timescale 1ns/1ps
module fms_unit_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_valid = 0, fault_next = 0;
	logic instr_in_delay_slot = 0, float_unit_disabled = 0, precision_mode_bit = 0, transfer_size_bit = 0;
	logic pready, pslverr, irq, instr_busy, instr_done, exc_valid, gr_wb_en, mem_wr_req, mem_ack, mem_fault, wb, err;
	logic [1:0] fault_kind = 0, mem_fault_kind;
	logic fault_late = 0;
	logic [2:0] exc_code, exc;
	logic [3:0] gr_wb_idx, lo, wbi;
	logic [11:0] paddr = 0;
	logic [15:0] instr_word = 0;
	logic [31:0] pwdata = 0, instr_rn_val = 0, index_general_reg_val = 0, prdata, gr_wb_data, mem_wr_addr, mem_wr_data;
	logic [31:0] rd, wbd, ea, w2a, w2d, fv [0:31];
	int errors = 0, samples_checked = 0, i, n0, nw, src;
	fms_unit fms_unit_inst (.*);
	fms_mem_model fms_mem_model_inst (.*);
	// bench clock, 10 ns
	initial forever #5 pclk = ~pclk;
	function automatic logic [31:0] exp_ea(input logic [3:0] l, input logic p, input logic [31:0] rn, r0);
		return l == 4'hb ? rn - (p ? 32'h8 : 32'h4) : l == 4'h7 ? r0 + rn : rn;
	endfunction
	task automatic check(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (k = 0; k < 9 && pready !== 1'b1; k++)
			@(posedge pclk);
		if (pready !== 1'b1)
			errors++;
		if (pready !== 1'b1)
			stop_test();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic fget(input int x);
		apb(1'b1, 12'h010, x);
		apb(1'b0, 12'h014, 0);
	endtask
	// offer one instruction and wait for its result pulse
	task automatic run(input logic [15:0] w);
		int k;
		n0 = fms_mem_model_inst.n_wr;
		@(posedge pclk);
		instr_word <= w;
		instr_valid <= 1'b1;
		@(posedge pclk);
		instr_valid <= 1'b0;
		for (k = 0; k < 60 && instr_done !== 1'b1 && exc_valid !== 1'b1; k++)
			@(posedge pclk);
		if (k == 60)
			errors++;
		if (k == 60)
			stop_test();
		exc = exc_valid ? exc_code : 3'h0;
		wb = gr_wb_en;
		wbd = gr_wb_data;
		wbi = gr_wb_idx;
		nw = fms_mem_model_inst.n_wr - n0;
	endtask
	initial
	begin
		void'($urandom(33));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h004, 0);
		check("status", rd, 0);
		apb(1'b1, 12'h000, 1);
		apb(1'b0, 12'h01c, 0);
		check("slverr", err, 1);
		for (i = 0; i < 32; i++)
		begin
			fv[i] = $urandom;
			apb(1'b1, 12'h010, i);
			apb(1'b1, 12'h014, fv[i]);
		end
		run(16'hf51c);
		fget(5);
		check("copy", rd, fv[1]);
		// single stores, then pair stores; 4 and 6 use the extended bank
		for (i = 0; i < 7; i++)
		begin
			transfer_size_bit <= (i > 2);
			instr_rn_val <= (i == 4) ? 32'h4 : $urandom;
			index_general_reg_val <= 32'hffff_fff0;
			lo = (i == 6 || i % 3 == 0) ? 4'ha : (i % 3 == 1) ? 4'hb : 4'h7;
			src = (i == 4 || i == 6) ? 16 : 2;
			run({8'hf3, (src == 16) ? 4'h1 : 4'h2, lo});
			ea = exp_ea(lo, i > 2, instr_rn_val, index_general_reg_val);
			check("words", nw, (i > 2) ? 2 : 1);
			check("addr", fms_mem_model_inst.wa[n0 % 16], ea);
			check("data", fms_mem_model_inst.wd[n0 % 16], fv[src]);
			// singles: request and busy must already be down when done shows
			w2a = (i > 2) ? fms_mem_model_inst.wa[(n0 + 1) % 16] : {31'h0, mem_wr_req};
			w2d = (i > 2) ? fms_mem_model_inst.wd[(n0 + 1) % 16] : {31'h0, instr_busy};
			check("addr2", w2a, (i > 2) ? ea + 4 : 32'h0);
			check("data2", w2d, (i > 2) ? fv[src + 1] : 32'h0);
			check("base", wb ? wbd : 32'h1, lo == 4'hb ? ea : 32'h1);
			check("base idx", wb ? wbi : 4'h3, 4'h3);
		end
		for (i = 0; i < 2; i++)
		begin
			run({4'hf, i ? 4'h3 : 4'h6, 8'h1c});
			fget(i ? 18 : 6);
			check("pair lo", rd, fv[16]);
			fget(i ? 19 : 7);
			check("pair hi", rd, fv[17]);
		end
		// slot store, disabled move, pair mode mismatch, unknown low nibble
		for (i = 0; i < 4; i++)
		begin
			{instr_in_delay_slot, float_unit_disabled, precision_mode_bit, transfer_size_bit} <=
				(i == 0) ? 4'hc : (i == 1) ? 4'h4 : (i == 2) ? 4'h3 : 4'h0;
			run((i == 1) ? 16'hf51c : (i == 3) ? 16'hf328 : 16'hf32b);
			check("exc", exc, (i >= 2) ? 7 : i + 1);
			check("quiet", nw + wb, 0);
		end
		{instr_in_delay_slot, float_unit_disabled, precision_mode_bit, transfer_size_bit} <= 4'h1;
		// the last pass faults the second word of the pair
		fault_next <= 1'b1;
		for (i = 0; i < 5; i++)
		begin
			fault_kind <= i[1:0];
			fault_late <= (i == 4);
			run(16'hf32b);
			check("fault", exc, 3 + i % 4);
			check("fault wb", wb, 0);
			check("fault words", nw, i == 4);
		end
		fault_next <= 1'b0;
		fault_late <= 1'b0;
		check("irq off", irq, 0);
		apb(1'b0, 12'h004, 0);
		check("sticky", rd, 32'hf);
		apb(1'b0, 12'h00c, 0);
		check("exc reg", rd, 32'h3);
		apb(1'b1, 12'h008, 32'h4);
		repeat (2) @(posedge pclk);
		check("irq on", irq, 1);
		apb(1'b1, 12'h004, 32'h4);
		repeat (2) @(posedge pclk);
		check("irq clr", irq, 0);
		stop_test();
	end
endmodule // fms_unit_tb
